// File: common/omc_pkg.sv
package omc_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SCA_OFF = 8'h38;
  localparam logic [7:0] SCB_OFF = 8'h3C;
  localparam logic [7:0] TBC_OFF = 8'h40;
  localparam logic [7:0] FLC_OFF = 8'h44;
  localparam logic [7:0] INT_OFF = 8'h48;
  localparam logic [7:0] STA_OFF = 8'h4C;
  localparam logic [7:0] SCA_RST = 8'h00;
  localparam logic [7:0] SCB_RST = 8'h80;
  // Field positions
  localparam int A_DORM = 7;
  localparam int A_WAKE_RELEASE_METHOD = 6;
  localparam int A_WAKE_RETURN_MODE = 5;
  localparam int A_HOLD = 4;
  localparam int A_WUT  = 2;
  localparam int B_XEN  = 7;
  localparam int B_SLOW_OSC_ENABLE = 6;
  localparam int B_SCK  = 5;
  localparam int B_IDLE = 4;
  localparam int B_TGH  = 2;
  localparam int T_EN   = 3;
  localparam int I_IMF  = 0;
  localparam int I_EF   = 1;
  localparam int I_LAT  = 2;
  // ----------------------------------------------------------------
  // Timing: frequencies in Hz, warm-up counts in oscillator periods
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int FC_HZ  = 50_000_000;
  localparam int FS_HZ  = 32_768;
  localparam int FAST_DIV = (CLK_HZ / FC_HZ < 1) ? 1 : CLK_HZ / FC_HZ;
  localparam int SLOW_DIV = (CLK_HZ / FS_HZ < 1) ? 1 : CLK_HZ / FS_HZ;
  localparam int WU_W = 18;
  localparam logic [WU_W-1:0] WU_FAST [4] =
    '{18'h30000, 18'h10000, 18'h0C000, 18'h04000};
  localparam logic [WU_W-1:0] WU_SLOW [4] =
    '{18'h06000, 18'h02000, 18'h000C0, 18'h00040};
  localparam logic [WU_W-1:0] FLW_FAST = 18'h00400;
  localparam logic [WU_W-1:0] FLW_SLOW = 18'h00008;
  // ----------------------------------------------------------------
  // Modes and clock controls
  // ----------------------------------------------------------------
  typedef enum logic [11:0] {
    RUN_FAST_SINGLE      = 12'h001,
    RUN_FAST_DUAL        = 12'h002,
    RUN_SLOW_DUAL        = 12'h004,
    RUN_SLOW_ONLY        = 12'h008,
    HALT_CPU_FAST_SINGLE = 12'h010,
    HALT_CPU_FAST_DUAL   = 12'h020,
    HALT_CPU_SLOW_ONLY   = 12'h040,
    HALT_CPU_SLOW_DUAL   = 12'h080,
    GATE_FAST            = 12'h100,
    GATE_SLOW            = 12'h200,
    DORMANT              = 12'h400,
    WARMUP               = 12'h800
  } omc_mode_t;
  typedef struct packed {
    logic fast_osc;
    logic slow_osc;
    logic sel_slow;
    logic cpu_run;
    logic wdt_run;
    logic periph;
    logic div_low;
    logic tbt;
  } omc_clk_t;
endpackage

// File: design/omc_top.sv
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Clock select 1 in fast dual moves to slow dual; 0 returns.
// - In slow dual, fast enable 0 enters slow only; 1 returns.
// - Slow only and its halt stop divider stages one to six.
// - Fast dual halt stops CPU and watchdog, returns to fast dual.
// - Slow only halt stops CPU, watchdog, fast osc; returns slow only.
// - Slow dual halt is slow only halt with fast osc running.
// - Peripheral halt in slow mode enters slow gate, only TBT clocked.
// - Falling edge of selected time-base source ends the gate.
// - Leaving slow gate always lands in slow only run.
// - Gate ignores TB enable; service needs master, irq, TB enables.
// - Slow gate entered with TB enable sets the TB latch on return.
// - Dormant bit stops all oscillators and holds internal state.
// - Release method: 0 edge, 1 level on the release pin.
// - After release, warm-up completes, then execution resumes.
// - Return mode 0 gives fast run, 1 gives slow only run.
// - Reset ends dormant into fast single regardless of return mode.
// - Port hold 0 floats outputs, 1 drives; release pin floats.
// - Dormant with hold 0 forces port inputs to zero.
// - Warm-up select picks one of four fast or slow counts.
// - Halt bit enters halt; any interrupt releases it.
// - Halt and peripheral halt bits clear on release.
// - Illegal oscillator enable combination generates a reset.
module omc_top
  import omc_pkg::*;
#(
  parameter int PORT_W   = 8,
  parameter int REL_BIT  = 0,
  parameter int WU_SHIFT = 0,
  parameter int F_DIV    = FAST_DIV,
  parameter int S_DIV    = SLOW_DIV
) (
  // Clock and reset
  input  wire logic              MCLK_IN,
  input  wire logic              RESET_IN,
  // Avalon-MM slave
  input  wire logic [7:0]        AVS_ADDRESS_IN,
  input  wire logic              AVS_READ_IN,
  input  wire logic              AVS_WRITE_IN,
  input  wire logic [31:0]       AVS_WRITEDATA_IN,
  input  wire logic [3:0]        AVS_BYTEENABLE_IN,
  output logic [31:0]            AVS_READDATA_OUT,
  output logic                   AVS_WAITREQUEST_OUT,
  // Wake and interrupt sources
  input  wire logic              RELEASE_PIN_IN,
  input  wire logic              IRQ_IN,
  input  wire logic [7:0]        TB_SRC_IN,
  // Ports
  input  wire logic [PORT_W-1:0] PORT_PIN_IN,
  input  wire logic [PORT_W-1:0] PORT_OE_IN,
  output logic [PORT_W-1:0]      PORT_IN_OUT,
  output logic [PORT_W-1:0]      PORT_OE_OUT,
  // Clock control and events
  output omc_clk_t               CLK_CTRL_OUT,
  output logic [11:0]            MODE_OUT,
  output logic                   IRQ_ACCEPT_OUT,
  output logic                   SYS_RESET_OUT
);
  initial begin
    if (REL_BIT >= PORT_W || F_DIV < 1 || S_DIV < 1 || WU_SHIFT > 6 ||
        F_DIV > 65536 || S_DIV > 65536)
      $error("omc_top: bad parameters");
  end

  omc_mode_t        st_reg;
  omc_mode_t        st_next;
  logic [7:0]       sca_reg;
  logic [7:0]       scb_reg;
  logic [3:0]       tbc_reg;
  logic             flc_reg;
  logic [2:0]       int_reg;
  logic             wait_reg;
  logic             rst_req_reg;
  logic             rst;
  logic             req;
  logic             wr_acc;
  logic [7:0]       wd;
  logic [1:0]       tick;
  logic             rel_q;
  logic             tb_q;
  logic             tb_fall;
  logic             gate_tb_reg;
  logic             ret_slow_reg;
  logic             flash_reg;
  logic             flash_ph_reg;
  logic [WU_W-1:0]  wu_cnt_reg;
  logic             wake;
  logic             wu_tick;
  logic             bad_b;

  // Soft reset from illegal enables shares the power-on path
  assign rst     = RESET_IN | rst_req_reg;
  assign req     = AVS_READ_IN | AVS_WRITE_IN;
  assign wr_acc  = AVS_WRITE_IN & ~wait_reg & AVS_BYTEENABLE_IN[0];
  assign wd      = AVS_WRITEDATA_IN[7:0];
  assign tb_fall = tb_q & ~TB_SRC_IN[tbc_reg[2:0]];
  assign bad_b   = wr_acc && AVS_ADDRESS_IN == SCB_OFF &&
                   ((!wd[B_XEN] && !wd[B_SLOW_OSC_ENABLE]) ||
                    (!wd[B_XEN] && !wd[B_SCK]) ||
                    (!wd[B_SLOW_OSC_ENABLE] && wd[B_SCK]));

  // ----------------------------------------------------------------
  // Oscillator tick dividers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_div
      localparam int DV = (gi == 0) ? F_DIV : S_DIV;
      logic [15:0] cnt_reg;
      always_ff @(posedge MCLK_IN) begin
        if (rst || cnt_reg == 16'(DV - 1)) begin
          cnt_reg <= 16'h0000;
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end
      assign tick[gi] = (cnt_reg == 16'(DV - 1));
    end
  endgenerate
  assign wu_tick = ret_slow_reg ? tick[1] : tick[0];

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~(req & wait_reg);
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      AVS_READDATA_OUT <= 32'h0000_0000;
    end else if (AVS_READ_IN && wait_reg) begin
      case (AVS_ADDRESS_IN)
        SCA_OFF: AVS_READDATA_OUT <= {24'h0, sca_reg[7:2], 2'b00};
        SCB_OFF: AVS_READDATA_OUT <= {24'h0, scb_reg[7:6],
                   CLK_CTRL_OUT.sel_slow, scb_reg[4], 1'b0,
                   scb_reg[2], 2'b00};
        TBC_OFF: AVS_READDATA_OUT <= {28'h0, tbc_reg};
        FLC_OFF: AVS_READDATA_OUT <= {31'h0, flc_reg};
        INT_OFF: AVS_READDATA_OUT <= {29'h0, int_reg};
        STA_OFF: AVS_READDATA_OUT <= {20'h0, MODE_OUT};
        default: AVS_READDATA_OUT <= 32'h0000_0000;
      endcase
    end
  end
  assign AVS_WAITREQUEST_OUT = wait_reg;

  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      rst_req_reg <= 1'b0;
    end else begin
      rst_req_reg <= bad_b;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (rst) begin
      sca_reg <= SCA_RST;
    end else if (wr_acc && AVS_ADDRESS_IN == SCA_OFF) begin
      sca_reg <= {wd[7:2], 2'b00};
    end else if (st_reg == WARMUP && st_next != WARMUP) begin
      sca_reg[A_DORM] <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (rst) begin
      scb_reg <= SCB_RST;
    end else begin
      if (wr_acc && AVS_ADDRESS_IN == SCB_OFF) begin
        scb_reg <= {wd[7:4], 1'b0, wd[2], 2'b00};
      end
      if (IRQ_IN && (st_reg[7:4] != 4'h0)) begin
        scb_reg[B_IDLE] <= 1'b0;
      end
      if (tb_fall && (st_reg == GATE_FAST || st_reg == GATE_SLOW)) begin
        scb_reg[B_TGH] <= 1'b0;
      end
      if (st_reg == WARMUP && st_next != WARMUP) begin
        scb_reg[B_SCK] <= ret_slow_reg;
        if (ret_slow_reg) begin
          scb_reg[B_XEN] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (rst) begin
      tbc_reg <= 4'h0;
      flc_reg <= 1'b0;
    end else if (wr_acc && AVS_ADDRESS_IN == TBC_OFF) begin
      tbc_reg <= wd[3:0];
    end else if (wr_acc && AVS_ADDRESS_IN == FLC_OFF) begin
      flc_reg <= wd[0];
    end
  end

  // TB latch: hardware set wins over a write-one clear
  always_ff @(posedge MCLK_IN) begin
    if (rst) begin
      int_reg <= 3'b000;
    end else begin
      if (wr_acc && AVS_ADDRESS_IN == INT_OFF) begin
        int_reg[1:0] <= wd[1:0];
        if (wd[I_LAT]) begin
          int_reg[I_LAT] <= 1'b0;
        end
      end
      if (st_reg == GATE_SLOW && tb_fall && gate_tb_reg) begin
        int_reg[I_LAT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Edge detection and captured context
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (rst) begin
      rel_q <= 1'b0;
      tb_q  <= 1'b0;
    end else begin
      rel_q <= RELEASE_PIN_IN;
      tb_q  <= TB_SRC_IN[tbc_reg[2:0]];
    end
  end

  // Edge or level release
  assign wake = sca_reg[A_WAKE_RELEASE_METHOD] ? RELEASE_PIN_IN
                                : (RELEASE_PIN_IN & ~rel_q);

  always_ff @(posedge MCLK_IN) begin
    if (rst) begin
      gate_tb_reg  <= 1'b0;
      ret_slow_reg <= 1'b0;
      flash_reg    <= 1'b0;
    end else if (st_next == GATE_SLOW && st_reg != GATE_SLOW) begin
      gate_tb_reg  <= tbc_reg[T_EN];
    // Level release can skip dormant and go straight to warm-up
    end else if (st_reg[3:0] != 4'h0 && sca_reg[A_DORM]) begin
      ret_slow_reg <= sca_reg[A_WAKE_RETURN_MODE];
      flash_reg    <= flc_reg;
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      RUN_FAST_SINGLE, RUN_FAST_DUAL, RUN_SLOW_DUAL, RUN_SLOW_ONLY: begin
        if (sca_reg[A_DORM]) begin
          st_next = (sca_reg[A_WAKE_RELEASE_METHOD] && RELEASE_PIN_IN) ? WARMUP
                                                        : DORMANT;
        end else if (scb_reg[B_IDLE]) begin
          // Slow dual and slow only swap order in the halt group
          st_next = omc_mode_t'({4'h0, st_reg[2], st_reg[3],
                                 st_reg[1:0], 4'h0});
        end else if (scb_reg[B_TGH]) begin
          st_next = st_reg[1:0] != 2'b00 ? GATE_FAST : GATE_SLOW;
        end else if (st_reg == RUN_FAST_SINGLE && scb_reg[B_SLOW_OSC_ENABLE]) begin
          st_next = RUN_FAST_DUAL;
        end else if (st_reg == RUN_FAST_DUAL) begin
          if (!scb_reg[B_SLOW_OSC_ENABLE]) begin
            st_next = RUN_FAST_SINGLE;
          end else if (scb_reg[B_SCK]) begin
            st_next = RUN_SLOW_DUAL;
          end
        end else if (st_reg == RUN_SLOW_DUAL) begin
          if (!scb_reg[B_SCK]) begin
            st_next = RUN_FAST_DUAL;
          end else if (!scb_reg[B_XEN]) begin
            st_next = RUN_SLOW_ONLY;
          end
        end else if (st_reg == RUN_SLOW_ONLY && scb_reg[B_XEN]) begin
          st_next = RUN_SLOW_DUAL;
        end
      end
      HALT_CPU_FAST_SINGLE, HALT_CPU_FAST_DUAL,
      HALT_CPU_SLOW_ONLY, HALT_CPU_SLOW_DUAL: begin
        if (IRQ_IN) begin
          st_next = omc_mode_t'({8'h00, st_reg[6], st_reg[7],
                                 st_reg[5:4]});
        end
      end
      GATE_FAST: begin
        if (tb_fall) begin
          st_next = RUN_FAST_SINGLE;
        end
      end
      GATE_SLOW: begin
        if (tb_fall) begin
          st_next = RUN_SLOW_ONLY;
        end
      end
      DORMANT: begin
        if (wake) begin
          st_next = WARMUP;
        end
      end
      WARMUP: begin
        if (wu_tick && wu_cnt_reg <= 18'h00001 &&
            (flash_ph_reg || !flash_reg)) begin
          st_next = ret_slow_reg ? RUN_SLOW_ONLY :
                    (scb_reg[B_SLOW_OSC_ENABLE] ? RUN_FAST_DUAL : RUN_FAST_SINGLE);
        end
      end
      default: st_next = RUN_FAST_SINGLE;
    endcase
  end

  // Reset, including reset out of dormant, lands in fast single
  always_ff @(posedge MCLK_IN) begin
    if (rst) begin
      st_reg <= RUN_FAST_SINGLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Warm-up count, then optional flash stabilisation wait
  always_ff @(posedge MCLK_IN) begin
    if (rst) begin
      wu_cnt_reg   <= 18'h00001;
      flash_ph_reg <= 1'b0;
    end else if (st_next == WARMUP && st_reg != WARMUP) begin
      wu_cnt_reg   <= (sca_reg[A_WAKE_RETURN_MODE] ? WU_SLOW[sca_reg[3:2]]
                       : WU_FAST[sca_reg[3:2]]) >> WU_SHIFT;
      flash_ph_reg <= 1'b0;
    end else if (st_reg == WARMUP && wu_tick) begin
      if (wu_cnt_reg > 18'h00001) begin
        wu_cnt_reg <= wu_cnt_reg - 18'h00001;
      end else if (!flash_ph_reg && flash_reg) begin
        wu_cnt_reg   <= ret_slow_reg ? FLW_SLOW : FLW_FAST;
        flash_ph_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (rst) begin
      CLK_CTRL_OUT <= '{fast_osc: 1'b1, cpu_run: 1'b1, wdt_run: 1'b1,
                        periph: 1'b1, div_low: 1'b1, tbt: 1'b1,
                        default: 1'b0};
    end else begin
      CLK_CTRL_OUT.fast_osc <= (st_reg[1:0] != 2'b00) ||
                               (st_reg[5:4] != 2'b00) ||
                               st_reg == RUN_SLOW_DUAL ||
                               st_reg == HALT_CPU_SLOW_DUAL ||
                               st_reg == GATE_FAST ||
                               (st_reg == WARMUP && !ret_slow_reg);
      CLK_CTRL_OUT.slow_osc <= !(st_reg == RUN_FAST_SINGLE ||
                               st_reg == HALT_CPU_FAST_SINGLE ||
                               st_reg == GATE_FAST ||
                               st_reg == DORMANT) ||
                               (st_reg == WARMUP && ret_slow_reg);
      // Slow source in slow dual, slow only, their halts and slow gate
      CLK_CTRL_OUT.sel_slow <= (st_reg[3:2] != 2'b00) ||
                               (st_reg[7:6] != 2'b00) ||
                               st_reg == GATE_SLOW;
      CLK_CTRL_OUT.cpu_run  <= st_reg[3:0] != 4'h0;
      CLK_CTRL_OUT.wdt_run  <= st_reg[3:0] != 4'h0;
      CLK_CTRL_OUT.periph   <= st_reg[7:0] != 8'h00;
      CLK_CTRL_OUT.div_low  <= !(st_reg == RUN_SLOW_ONLY ||
                               (st_reg[7:6] != 2'b00) ||
                               st_reg == GATE_SLOW ||
                               st_reg == DORMANT);
      CLK_CTRL_OUT.tbt      <= st_reg != DORMANT && st_reg != WARMUP;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (rst) begin
      MODE_OUT       <= RUN_FAST_SINGLE;
      IRQ_ACCEPT_OUT <= 1'b0;
    end else begin
      MODE_OUT       <= st_reg;
      IRQ_ACCEPT_OUT <= ((st_reg[7:4] != 4'h0) && IRQ_IN &&
                         int_reg[I_IMF]) ||
                        ((st_reg == GATE_SLOW || st_reg == GATE_FAST) &&
                         tb_fall && int_reg[I_IMF] && int_reg[I_EF] &&
                         tbc_reg[T_EN]);
    end
  end
  assign SYS_RESET_OUT = rst_req_reg;

  always_ff @(posedge MCLK_IN) begin
    if (rst) begin
      PORT_OE_OUT <= '0;
      PORT_IN_OUT <= '0;
    end else if (st_reg == DORMANT) begin
      PORT_OE_OUT <= sca_reg[A_HOLD] ? PORT_OE_IN : '0;
      PORT_OE_OUT[REL_BIT] <= 1'b0;
      PORT_IN_OUT <= sca_reg[A_HOLD] ? PORT_PIN_IN : '0;
    end else begin
      PORT_OE_OUT <= PORT_OE_IN;
      PORT_IN_OUT <= PORT_PIN_IN;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_bad_wr;
    bad_b;
  endsequence
  sequence s_rst_land;
    SYS_RESET_OUT ##1 st_reg == RUN_FAST_SINGLE;
  endsequence

  a_fast_to_slow:
  assert property (@(posedge MCLK_IN) disable iff (rst)
    st_reg == RUN_FAST_DUAL && scb_reg[B_SCK] && scb_reg[B_SLOW_OSC_ENABLE] &&
    !sca_reg[A_DORM] && !scb_reg[B_IDLE] && !scb_reg[B_TGH] |=>
    st_reg == RUN_SLOW_DUAL) else $error("bad slow entry");
  a_div_stop:
  assert property (@(posedge MCLK_IN) disable iff (rst)
    st_reg == RUN_SLOW_ONLY || st_reg == HALT_CPU_SLOW_ONLY |=>
    !CLK_CTRL_OUT.div_low) else $error("divider not stopped");
  a_halt_fast:
  assert property (@(posedge MCLK_IN) disable iff (rst)
    st_reg == HALT_CPU_FAST_DUAL |=> !CLK_CTRL_OUT.cpu_run &&
    CLK_CTRL_OUT.fast_osc && CLK_CTRL_OUT.slow_osc)
    else $error("fast dual halt wrong");
  a_halt_slow:
  assert property (@(posedge MCLK_IN) disable iff (rst)
    st_reg == HALT_CPU_SLOW_ONLY |=> !CLK_CTRL_OUT.fast_osc &&
    !CLK_CTRL_OUT.wdt_run && CLK_CTRL_OUT.periph)
    else $error("slow halt wrong");
  a_halt_dual:
  assert property (@(posedge MCLK_IN) disable iff (rst)
    st_reg == HALT_CPU_SLOW_DUAL |=> CLK_CTRL_OUT.fast_osc &&
    CLK_CTRL_OUT.sel_slow && !CLK_CTRL_OUT.cpu_run)
    else $error("slow dual halt wrong");
  a_halt_enter:
  assert property (@(posedge MCLK_IN) disable iff (rst)
    st_reg == RUN_SLOW_DUAL && scb_reg[B_IDLE] && !sca_reg[A_DORM] |=>
    st_reg == HALT_CPU_SLOW_DUAL) else $error("wrong halt entered");
  a_halt_back:
  assert property (@(posedge MCLK_IN) disable iff (rst)
    st_reg == HALT_CPU_SLOW_ONLY && IRQ_IN |=>
    st_reg == RUN_SLOW_ONLY && !scb_reg[B_IDLE])
    else $error("slow halt release wrong");
  a_gate_exit:
  assert property (@(posedge MCLK_IN) disable iff (rst)
    st_reg == GATE_SLOW && tb_fall |=> st_reg == RUN_SLOW_ONLY ##1
    CLK_CTRL_OUT.periph) else $error("gate exit wrong");
  a_tb_latch:
  assert property (@(posedge MCLK_IN) disable iff (rst)
    st_reg == GATE_SLOW && tb_fall && gate_tb_reg |=> int_reg[I_LAT])
    else $error("tb latch not set");
  a_dorm_off:
  assert property (@(posedge MCLK_IN) disable iff (rst)
    st_reg == DORMANT [*2] |-> !CLK_CTRL_OUT.fast_osc &&
    !CLK_CTRL_OUT.slow_osc && !CLK_CTRL_OUT.cpu_run)
    else $error("dormant clocks on");
  a_port_zero:
  assert property (@(posedge MCLK_IN) disable iff (rst)
    st_reg == DORMANT && !sca_reg[A_HOLD] |=> PORT_IN_OUT == '0 &&
    !PORT_OE_OUT[REL_BIT]) else $error("dormant port not cleared");
  a_osc_reset:
  assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    s_bad_wr |=> s_rst_land) else $error("no reset on bad enables");
endmodule // omc_top
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import omc_pkg::*;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic [7:0]  addr    = 8'h00;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wdat    = 32'h0;
  logic [3:0]  ben     = 4'h0;
  logic        rel_pin = 1'b0;
  logic        irq     = 1'b0;
  logic [7:0]  tb_src  = 8'h00;
  logic [7:0]  pin_in  = 8'h00;
  logic [7:0]  oe_in   = 8'h00;
  logic [31:0] rdat;
  logic        wait_r;
  logic [7:0]  port_in;
  logic [7:0]  port_oe;
  omc_clk_t    clk_ctrl;
  logic [11:0] mode;
  logic        irq_acc;
  logic        sys_rst;
  int          acc_cnt = 0;
  int          acc_base = 0;
  logic        rst_seen = 1'b0;
  logic [31:0] r;
  logic [2:0]  src;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  integer      seed = 32'he326;
  always #10 clk = ~clk;
  // Shorter warm-up: table shifted by 6, slow tick every 2 clocks
  omc_top #(.WU_SHIFT(6), .S_DIV(2)) u_omc_top (
    .MCLK_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat),
    .AVS_BYTEENABLE_IN(ben), .AVS_READDATA_OUT(rdat),
    .AVS_WAITREQUEST_OUT(wait_r), .RELEASE_PIN_IN(rel_pin),
    .IRQ_IN(irq), .TB_SRC_IN(tb_src), .PORT_PIN_IN(pin_in),
    .PORT_OE_IN(oe_in), .PORT_IN_OUT(port_in), .PORT_OE_OUT(port_oe),
    .CLK_CTRL_OUT(clk_ctrl), .MODE_OUT(mode),
    .IRQ_ACCEPT_OUT(irq_acc), .SYS_RESET_OUT(sys_rst));
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (irq_acc === 1'b1) acc_cnt <= acc_cnt + 1;
    if (sys_rst === 1'b1) rst_seen <= 1'b1;
    if (cycles == 60000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ---------------------------------------------------------------
  // Tasks and expectations
  // ---------------------------------------------------------------
  task automatic print_verdict();
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    int k;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {24'h0, d};
    ben <= be;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wait_r !== 1'b0 && k < 50);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 50) chk(32'h1, 32'h0);
  endtask
  task automatic wait_mode(input logic [11:0] exp);
    for (int k = 0; k < 40 && mode !== exp; k++) @(posedge clk);
    chk({20'h0, mode}, {20'h0, exp});
  endtask
  task automatic chk_clk(input logic [7:0] exp);
    @(posedge clk);
    chk({24'h0, clk_ctrl}, {24'h0, exp});
  endtask
  task automatic irq_rel(input logic [11:0] exp);
    irq <= 1'b1;
    wait_mode(exp);
    irq <= 1'b0;
  endtask
  function automatic int wu_cyc(input int s, input logic slw,
                                input logic fl);
    int f[4] = '{3 << 16, 1 << 16, 3 << 14, 1 << 14};
    int w[4] = '{3 << 13, 1 << 13, 3 << 6, 1 << 6};
    if (slw) return 2 * ((w[s] >> 6) + (fl ? 8 : 0));
    return (f[s] >> 6) + (fl ? 1024 : 0);
  endfunction
  task automatic dormant(input logic [7:0] a, input logic fl,
                         input int exp_cyc, input logic [11:0] ret);
    int k;
    bus(1'b1, FLC_OFF, {7'h0, fl}, 4'h1);
    rel_pin <= a[6];
    bus(1'b1, SCA_OFF, a, 4'h1);
    if (!a[6]) begin
      wait_mode(DORMANT);
      chk_clk(8'h00);
      chk(port_oe, a[4] ? oe_in & 8'hFE : 8'h00);
      chk(port_in, a[4] ? pin_in : 8'h00);
      rel_pin <= 1'b1;
    end
    wait_mode(WARMUP);
    k = 0;
    while (mode === WARMUP && k < 9000) begin
      @(posedge clk);
      k++;
    end
    chk(k > exp_cyc - 6 && k < exp_cyc + 6, 32'h1);
    wait_mode(ret);
    rel_pin <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    pin_in <= 8'($random(seed));
    oe_in <= 8'($random(seed));
    bus(1'b0, SCA_OFF, 8'h00, 4'h1);
    chk(r, {24'h0, SCA_RST});
    bus(1'b0, SCB_OFF, 8'h00, 4'h1);
    chk(r, {24'h0, SCB_RST});
    bus(1'b0, 8'h20, 8'h00, 4'h1);
    chk(r, 32'h0);
    bus(1'b1, SCA_OFF, 8'h80, 4'h0);
    repeat (4) @(posedge clk);
    wait_mode(RUN_FAST_SINGLE);
    for (int i = 0; i < 4; i++)
      dormant({3'b100, 1'($random(seed)), 2'(i), 2'b00}, i == 1,
              wu_cyc(i, 1'b0, i == 1), RUN_FAST_SINGLE);
    bus(1'b1, INT_OFF, 8'h01, 4'h1);
    bus(1'b1, SCB_OFF, 8'hC0, 4'h1);
    wait_mode(RUN_FAST_DUAL);
    bus(1'b1, SCB_OFF, 8'hD0, 4'h1);
    wait_mode(HALT_CPU_FAST_DUAL);
    chk_clk(8'hC7);
    irq_rel(RUN_FAST_DUAL);
    chk({31'h0, acc_cnt > 0}, 32'h1);
    bus(1'b1, SCB_OFF, 8'hE0, 4'h1);
    wait_mode(RUN_SLOW_DUAL);
    bus(1'b1, SCB_OFF, 8'hC0, 4'h1);
    wait_mode(RUN_FAST_DUAL);
    bus(1'b1, SCB_OFF, 8'hE0, 4'h1);
    wait_mode(RUN_SLOW_DUAL);
    bus(1'b1, SCB_OFF, 8'hF0, 4'h1);
    wait_mode(HALT_CPU_SLOW_DUAL);
    chk_clk(8'hE5);
    irq_rel(RUN_SLOW_DUAL);
    bus(1'b1, SCB_OFF, 8'h60, 4'h1);
    wait_mode(RUN_SLOW_ONLY);
    chk_clk(8'h7D);
    bus(1'b1, SCB_OFF, 8'h70, 4'h1);
    wait_mode(HALT_CPU_SLOW_ONLY);
    chk_clk(8'h65);
    irq_rel(RUN_SLOW_ONLY);
    bus(1'b0, SCB_OFF, 8'h00, 4'h1);
    chk(r, 32'h60);
    bus(1'b1, SCB_OFF, 8'hE0, 4'h1);
    wait_mode(RUN_SLOW_DUAL);
    bus(1'b1, SCB_OFF, 8'h60, 4'h1);
    wait_mode(RUN_SLOW_ONLY);
    src = 3'($random(seed));
    bus(1'b1, TBC_OFF, {5'b00001, src}, 4'h1);
    bus(1'b1, INT_OFF, 8'h03, 4'h1);
    acc_base = acc_cnt;
    bus(1'b1, SCB_OFF, 8'h64, 4'h1);
    wait_mode(GATE_SLOW);
    chk_clk(8'h61);
    tb_src[src] <= 1'b1;
    repeat (4) @(posedge clk);
    chk({20'h0, mode}, {20'h0, GATE_SLOW});
    tb_src[src] <= 1'b0;
    wait_mode(RUN_SLOW_ONLY);
    repeat (3) @(posedge clk);
    chk({31'h0, acc_cnt > acc_base}, 32'h1);
    bus(1'b0, INT_OFF, 8'h00, 4'h1);
    chk(r & 32'h4, 32'h4);
    bus(1'b0, SCB_OFF, 8'h00, 4'h1);
    chk(r, 32'h60);
    dormant({3'b101, 1'($random(seed)), 2'(src), 2'b00}, 1'b0,
            wu_cyc(src[1:0], 1'b1, 1'b0), RUN_SLOW_ONLY);
    dormant(8'hF0, 1'b0, wu_cyc(0, 1'b1, 1'b0), RUN_SLOW_ONLY);
    bus(1'b1, SCA_OFF, 8'hA0, 4'h1);
    wait_mode(DORMANT);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wait_mode(RUN_FAST_SINGLE);
    bus(1'b1, SCB_OFF, 8'h00, 4'h1);
    repeat (4) @(posedge clk);
    chk(rst_seen, 32'h1);
    wait_mode(RUN_FAST_SINGLE);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
